// file: inc/io_expander_defs.vh
`ifndef IO_EXPANDER_DEFS_VH
`define IO_EXPANDER_DEFS_VH

// Fixed upper bits of the seven-bit slave address.
`define SLV_ADDR_HI       4'h4
// Command codes of the eight registers.
`define CMD_IN0           3'h0
`define CMD_IN1           3'h1
`define CMD_OUT0          3'h2
`define CMD_OUT1          3'h3
`define CMD_POL0          3'h4
`define CMD_POL1          3'h5
`define CMD_CFG0          3'h6
`define CMD_CFG1          3'h7
// Register reset values.
`define RST_OUT           8'hFF
`define RST_POL           8'h00
`define RST_CFG           8'hFF
`define RST_CMD           3'h0
// Bits per byte before the acknowledge slot.
`define BITS_PER_BYTE     4'h8

`endif

// file: rtl/io_expander.v
`timescale 1ns/100ps
`include "io_expander_defs.vh"

module io_expander (
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_out,
  input  wire        addr_strap_0_in,
  input  wire        addr_strap_1_in,
  input  wire        addr_strap_2_in,
  input  wire [15:0] port_pin_in,
  output reg  [15:0] high_side_driver_out,
  output reg  [15:0] low_side_driver_out,
  output reg         alert_n_out,
  output reg         alert_n_oe_out
);

  // Bus machine states.
  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_AACK  = 3'd2;
  localparam ST_WRX   = 3'd3;
  localparam ST_WACK  = 3'd4;
  localparam ST_RTX   = 3'd5;
  localparam ST_RACK  = 3'd6;

  // Two-flop synchronisers; only the second stage and beyond feed logic.
  reg  [1:0]  scl_sync_q;
  reg  [1:0]  sda_sync_q;
  reg         scl_prev_q;
  reg         sda_prev_q;
  reg  [2:0]  strap_s1_q;
  reg  [2:0]  strap_s2_q;
  reg  [15:0] pin_s1_q;
  reg  [15:0] pin_s2_q;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      pin_s1_q   <= 16'h0000;
      pin_s2_q   <= 16'h0000;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
      strap_s1_q <= {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};
      strap_s2_q <= strap_s1_q;
      pin_s1_q   <= port_pin_in;
      pin_s2_q   <= pin_s1_q;
    end
  end

  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  // SDA moving while SCL stays high is a control event, not data.
  wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Own address: fixed high nibble plus straps.
  wire [6:0] own_addr = {`SLV_ADDR_HI, strap_s2_q};

  // Registers and bus machine state.
  reg  [2:0]  state_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  shift_q;
  reg  [2:0]  cmd_q;
  reg         cmd_seen_q;
  reg  [7:0]  out0_q;
  reg  [7:0]  out1_q;
  reg  [7:0]  pol0_q;
  reg  [7:0]  pol1_q;
  reg  [7:0]  cfg0_q;
  reg  [7:0]  cfg1_q;
  reg  [15:0] in_cap_q;
  reg         rd_nack_q;

  // Reported input value with polarity applied.
  wire [15:0] in_view = pin_s2_q ^ {pol1_q, pol0_q};

  // Read multiplexer over the eight registers.
  reg [7:0] rd_data;
  always @* begin
    case (cmd_q)
      `CMD_IN0:  rd_data = in_view[7:0];
      `CMD_IN1:  rd_data = in_view[15:8];
      `CMD_OUT0: rd_data = out0_q;
      `CMD_OUT1: rd_data = out1_q;
      `CMD_POL0: rd_data = pol0_q;
      `CMD_POL1: rd_data = pol1_q;
      `CMD_CFG0: rd_data = cfg0_q;
      default:   rd_data = cfg1_q;
    endcase
  end

  // Pair partner: flip the low bit of the selection.
  wire [2:0] cmd_next = {cmd_q[2:1], ~cmd_q[0]};

  // Data of the partner register, preloaded for the next read byte.
  reg [7:0] rd_data_next;
  always @* begin
    case (cmd_next)
      `CMD_IN0:  rd_data_next = in_view[7:0];
      `CMD_IN1:  rd_data_next = in_view[15:8];
      `CMD_OUT0: rd_data_next = out0_q;
      `CMD_OUT1: rd_data_next = out1_q;
      `CMD_POL0: rd_data_next = pol0_q;
      `CMD_POL1: rd_data_next = pol1_q;
      `CMD_CFG0: rd_data_next = cfg0_q;
      default:   rd_data_next = cfg1_q;
    endcase
  end

  // A read of an input port captures it, as a stop does; either one clears that port's alert.
  reg cap0_pulse;
  reg cap1_pulse;
  always @* begin
    cap0_pulse = 1'b0;
    cap1_pulse = 1'b0;
    if (state_q == ST_RACK && scl_fall) begin
      cap0_pulse = (cmd_q == `CMD_IN0);
      cap1_pulse = (cmd_q == `CMD_IN1);
    end
  end

  // Bus machine and register writes.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      cmd_q      <= `RST_CMD;
      cmd_seen_q <= 1'b0;
      out0_q     <= `RST_OUT;
      out1_q     <= `RST_OUT;
      pol0_q     <= `RST_POL;
      pol1_q     <= `RST_POL;
      cfg0_q     <= `RST_CFG;
      cfg1_q     <= `RST_CFG;
      rd_nack_q  <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_ev) begin
      // A repeated start is taken at any point and restarts the address phase.
      state_q    <= ST_ADDR;
      bit_cnt_q  <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_ev) begin
      state_q    <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        ST_ADDR, ST_WRX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
            bit_cnt_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              // General call (all zero) never matches the 0100 prefix.
              if (shift_q[7:1] == own_addr && shift_q[7:1] != 7'h00) begin
                sda_oe_out <= 1'b1;
                cmd_seen_q <= 1'b0;
                state_q    <= ST_AACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              sda_oe_out <= 1'b1;
              state_q    <= ST_WACK;
              if (!cmd_seen_q) begin
                cmd_q      <= shift_q[2:0];
                cmd_seen_q <= 1'b1;
              end else begin
                case (cmd_q)
                  `CMD_OUT0: out0_q <= shift_q;
                  `CMD_OUT1: out1_q <= shift_q;
                  `CMD_POL0: pol0_q <= shift_q;
                  `CMD_POL1: pol1_q <= shift_q;
                  `CMD_CFG0: cfg0_q <= shift_q;
                  `CMD_CFG1: cfg1_q <= shift_q;
                  default:   ;
                endcase
                cmd_q <= cmd_next;
              end
            end
          end
        end
        ST_AACK: begin
          // Drive low through the whole high phase; on falling SCL release for a write, or put out the first data bit for a read.
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (shift_q[0]) begin
              sda_oe_out <= ~rd_data[7];
              shift_q    <= {rd_data[6:0], 1'b0};
              state_q    <= ST_RTX;
            end else begin
              sda_oe_out <= 1'b0;
              state_q    <= ST_WRX;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            state_q    <= ST_WRX;
          end
        end
        ST_RTX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == `BITS_PER_BYTE) begin
              sda_oe_out <= 1'b0;
              state_q    <= ST_RACK;
            end else begin
              sda_oe_out <= ~shift_q[7];
              shift_q    <= {shift_q[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            rd_nack_q <= sda_s;
          end else if (scl_fall) begin
            if (rd_nack_q) begin
              sda_oe_out <= 1'b0;
              state_q    <= ST_IDLE;
            end else begin
              // Sequential reads alternate within the selected pair.
              bit_cnt_q  <= 4'h0;
              cmd_q      <= cmd_next;
              sda_oe_out <= ~rd_data_next[7];
              shift_q    <= {rd_data_next[6:0], 1'b0};
              state_q    <= ST_RTX;
            end
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // Input capture: refreshed when a port is read or on stop, which clears the alert.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      in_cap_q <= 16'h0000;
    end else begin
      if (cap0_pulse || stop_ev) begin
        in_cap_q[7:0] <= pin_s2_q[7:0];
      end
      if (cap1_pulse || stop_ev) begin
        in_cap_q[15:8] <= pin_s2_q[15:8];
      end
    end
  end

  // Mismatch on an input-configured pin raises the alert; a pin returning
  // to its captured value drops it again without any read.
  wire [15:0] cfg_all  = {cfg1_q, cfg0_q};
  wire        mismatch = |((pin_s2_q ^ in_cap_q) & cfg_all);

  // Pin drivers and open-drain alert, all registered.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      high_side_driver_out <= 16'h0000;
      low_side_driver_out  <= 16'h0000;
      alert_n_out          <= 1'b0;
      alert_n_oe_out       <= 1'b0;
    end else begin
      high_side_driver_out <= ~cfg_all & {out1_q, out0_q};
      low_side_driver_out  <= ~cfg_all & ~{out1_q, out0_q};
      alert_n_out          <= 1'b0;
      alert_n_oe_out       <= mismatch;
    end
  end

endmodule

// file: tb/i2c_master_model.sv
`timescale 1ns/100ps
// Bus master; moves only on falling system edges, SCL stands high between frames.
module i2c_master_model (
  input  wire  clk_in,
  input  wire  sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // Idle bus at time zero.
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // A 160 ns slot with a long low phase, so the device's late answer lands before SCL rises.
  task automatic slot(input logic b, output logic s);
    scl_out = 1'b0;
    wait_n(2);
    sda_pull_out = ~b;
    wait_n(4);
    scl_out = 1'b1;
    wait_n(2);
    s = sda_in;
  endtask
  // Start from an idle bus only.
  task automatic start();
    wait_n(4);
    sda_pull_out = 1'b1;
    wait_n(4);
  endtask
  // Stop, then leave the bus idle.
  task automatic stop();
    scl_out = 1'b0;
    wait_n(2);
    sda_pull_out = 1'b1;
    wait_n(4);
    scl_out = 1'b1;
    wait_n(2);
    sda_pull_out = 1'b0;
    wait_n(8);
  endtask
  // Send a byte MSB first, then release SDA for the acknowledge slot.
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask
  // Take a byte; only the last is left unacknowledged.
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
    slot(last, s);
  endtask
endmodule

// file: tb/io_expander_chk.sv
`timescale 1ns/100ps
// Pin-level checks of the expander, all on the system clock.
module io_expander_chk (
  input wire        sys_clk_in,
  input wire        sys_rst_in,
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe_out,
  input wire [15:0] port_pin_in,
  input wire [15:0] high_side_driver_out,
  input wire [15:0] low_side_driver_out,
  input wire        alert_n_out,
  input wire        alert_n_oe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Driver and open-drain relations.
  drv_excl_a: assert property ((high_side_driver_out & low_side_driver_out) == 16'h0000)
    else $error("pin driven both ways");
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("sda value not low");
  alert_low_a: assert property (alert_n_out == 1'b0)
    else $error("alert value not low");
  rst_idle_a: assert property ($past(sys_rst_in) |-> !sda_oe_out && !alert_n_oe_out
    && (high_side_driver_out | low_side_driver_out) == 16'h0000) else $error("not idle after reset");
  // Only SCL low may see SDA or pins move; a change while high would be a false bus event.
  sda_move_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("sda moved while scl high");
  ack_hold_a: assert property ($rose(scl_in) && sda_oe_out |-> sda_oe_out [*3])
    else $error("sda low not held");
  drv_move_a: assert property ($changed(high_side_driver_out) || $changed(low_side_driver_out) |-> !scl_in)
    else $error("drivers moved while scl high");
  alert_stop_a: assert property (scl_in && $rose(sda_in) ##1 $stable(port_pin_in) [*6] |=> !alert_n_oe_out)
    else $error("alert kept after stop");
  cover property ($rose(sda_oe_out));
  cover property ($rose(alert_n_oe_out));
  cover property ($fell(alert_n_oe_out));
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic        sys_clk_in;
  logic        sys_rst_in;
  logic        scl_in;
  logic        sda_pull;
  logic [15:0] ext_level;
  logic [15:0] d;
  logic [2:0]  strap;
  wire         sda_in;
  wire         sda_out;
  wire         sda_oe_out;
  wire  [15:0] port_pin_in;
  wire  [15:0] high_side_driver_out;
  wire  [15:0] low_side_driver_out;
  wire         alert_n_out;
  wire         alert_n_oe_out;
  int          errors;
  int          cmp_count;
  // SDA has a pull-up; pins follow the device's drivers, else the outside level.
  assign sda_in = ~(sda_pull | sda_oe_out);
  assign port_pin_in = high_side_driver_out | (ext_level & ~low_side_driver_out);
  io_expander DUT (.sys_clk_in, .sys_rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .addr_strap_0_in(strap[0]), .addr_strap_1_in(strap[1]), .addr_strap_2_in(strap[2]),
    .port_pin_in, .high_side_driver_out, .low_side_driver_out, .alert_n_out, .alert_n_oe_out);
  i2c_master_model bus (.clk_in(sys_clk_in), .sda_in, .scl_out(scl_in), .sda_pull_out(sda_pull));
  // System clock, 20 ns.
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Write n bytes of b, MSB byte first; only the strapped address may answer.
  task automatic wr(input logic [6:0] a, input logic [23:0] b, input int n);
    logic k;
    bus.start();
    bus.put({a, 1'b0}, k);
    chk(k, a == {4'h4, strap});
    for (int i = n - 1; i >= 0 && k; i--) begin
      bus.put(b[8*i +: 8], k);
      chk(k, 1'b1);
    end
    bus.stop();
  endtask
  // Read n bytes (at most two) into d.
  task automatic rd(input int n, output logic [15:0] r);
    logic [7:0] v;
    logic k;
    bus.start();
    bus.put({4'h4, strap, 1'b1}, k);
    chk(k, 1'b1);
    r = 16'h0000;
    for (int i = n; i > 0; i--) begin
      bus.get(i == 1, v);
      r = {r[7:0], v};
    end
    bus.stop();
  endtask
  // A hang ends the run as a failure.
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    errors++;
    wrap_up();
  end
  initial begin
    sys_rst_in = 1'b1;
    ext_level = 16'h0000;
    strap = 3'b101;
    repeat (16) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk(high_side_driver_out | low_side_driver_out, 16'h0000);
    chk(alert_n_oe_out, 1'b0);
    wr(7'h00, 24'h00_0000, 0);
    wr(7'h24, 24'h00_0000, 0);
    wr(7'h25, 24'h02_A53C, 3);
    wr(7'h25, 24'h06_00F0, 3);
    chk(high_side_driver_out, 16'h0CA5);
    chk(low_side_driver_out, 16'h035A);
    // Moving the straps while the bus is idle moves the address with them.
    strap = 3'b010;
    wr(7'h22, 24'h00_0000, 0);
    wr(7'h25, 24'h00_0000, 0);
    strap = 3'b101;
    wr(7'h25, 24'h00_0003, 1);
    rd(2, d);
    chk(d, 16'h3CA5);
    ext_level = 16'h5000;
    repeat (8) @(negedge sys_clk_in);
    chk(alert_n_oe_out, 1'b1);
    // A pin that returns to its captured level drops the alert without a read.
    ext_level = 16'h0000;
    repeat (8) @(negedge sys_clk_in);
    chk(alert_n_oe_out, 1'b0);
    ext_level = 16'h5000;
    repeat (8) @(negedge sys_clk_in);
    chk(alert_n_oe_out, 1'b1);
    wr(7'h25, 24'h00_05F0, 2);
    chk(alert_n_oe_out, 1'b0);
    wr(7'h25, 24'h00_0001, 1);
    rd(2, d);
    chk(d, 16'hACA5);
    // A reset in mid-run must bring back the default directions.
    ext_level = 16'h0000;
    sys_rst_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk(high_side_driver_out | low_side_driver_out, 16'h0000);
    chk(alert_n_oe_out, 1'b0);
    wr(7'h25, 24'h00_0006, 1);
    rd(2, d);
    chk(d, 16'hFFFF);
    wrap_up();
  end
endmodule
bind io_expander io_expander_chk chk (.sys_clk_in, .sys_rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
  .port_pin_in, .high_side_driver_out, .low_side_driver_out, .alert_n_out, .alert_n_oe_out);
